// *** core/clk_host_pkg.sv ***
// constants, types and device register map for the cpu clock source switch controller
// Operation
// - X1 crystal: clear ext main, set X1 mode, run oscillator, check stabilization, select
// - external main clock: set ext main and X1 mode, run, no stabilization check, select
// - highspeed_src_sel write may be left out when already holding the needed value
// - XT1 crystal: clear start and ext sub, set XT1 mode, wait stabilization, set sub select
// - external subsystem clock: clear start, set ext sub and XT1 mode, no wait, select
// - high-speed to subsystem uses the same sequence as from the internal oscillator
// - subsystem setup writes may be skipped when the cpu already runs from it
// - back to internal oscillator: run it, see stable flag, then clear main source
// - subsystem back to internal: run, wait stable, clear main source, then clear sub select
// - main source clear may be skipped there when highspeed_src_sel is zero
package clk_host_pkg;

  // ****************************************
  // device register indices
  // ****************************************
  localparam logic [7:0] DREG_PIN_MODE = 8'h00;
  localparam logic [7:0] DREG_MAIN_OSC = 8'h01;
  localparam logic [7:0] DREG_MAIN_CLK = 8'h02;
  localparam logic [7:0] DREG_CPU_CLK = 8'h03;
  localparam logic [7:0] DREG_INT_OSC = 8'h04;
  localparam logic [7:0] DREG_OSC_STAB = 8'h05;

  // ****************************************
  // device field positions
  // ****************************************
  localparam int PIN_EXT_MAIN_BIT = 7;
  localparam int PIN_X1_MODE_BIT = 6;
  localparam int PIN_EXT_SUB_BIT = 5;
  localparam int PIN_XT1_MODE_BIT = 4;
  localparam int MOC_STOP_BIT = 7;
  localparam int MCM_HS_SRC_BIT = 2;
  localparam int MCM_MAIN_SRC_BIT = 0;
  localparam int PCC_XT1_START_BIT = 6;
  localparam int PCC_SUB_SEL_BIT = 4;
  localparam int RCM_STABLE_BIT = 7;
  localparam int RCM_STOP_BIT = 0;

  // ****************************************
  // device reset images kept in the shadows
  // ****************************************
  localparam logic [7:0] PIN_MODE_RST = 8'h00;
  localparam logic [7:0] MAIN_OSC_RST = 8'h80;
  localparam logic [7:0] MAIN_CLK_RST = 8'h00;
  localparam logic [7:0] CPU_CLK_RST = 8'h00;
  localparam logic [7:0] INT_OSC_RST = 8'h00;

  // ****************************************
  // controller registers on the ahb side
  // ****************************************
  localparam logic [7:0] AREG_CMD = 8'h00;
  localparam logic [7:0] AREG_STATUS = 8'h04;
  localparam logic [7:0] AREG_STAB_WAIT = 8'h08;
  localparam logic [7:0] AREG_STAB_MASK = 8'h0C;
  localparam int CMD_GO_BIT = 8;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_HIGHSPEED_SRC_SEL_BIT = 2;
  localparam int STAT_ERR_BIT = 3;
  localparam int STAT_SRC_LSB = 4;
  localparam logic [15:0] STAB_WAIT_RST = 16'h0100;
  localparam logic [7:0] STAB_MASK_RST = 8'hFF;

  // ****************************************
  // timing
  // ****************************************
  // longest old-source run after a select write, in cycles
  localparam logic [7:0] SWITCH_SETTLE_CYC = 8'h10;
  localparam logic [7:0] SETTLE_LAST = SWITCH_SETTLE_CYC - 8'h01;

  typedef enum logic [2:0] {
    CMD_TO_X1 = 3'h0,
    CMD_TO_EXT_MAIN = 3'h1,
    CMD_TO_XT1 = 3'h2,
    CMD_TO_EXT_SUB = 3'h3,
    CMD_TO_HSOSC = 3'h4
  } clk_cmd_t;

  typedef enum logic [1:0] {
    SRC_HSOSC = 2'h0,
    SRC_MAIN = 2'h1,
    SRC_SUB = 2'h2
  } clk_src_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_PIN = 3'b001,
    ST_OSC = 3'b011,
    ST_STAB = 3'b010,
    ST_SEL1 = 3'b110,
    ST_SEL2 = 3'b111,
    ST_SETTLE = 3'b101,
    ST_DONE = 3'b100
  } seq_state_t;

  typedef struct packed {
    logic we;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dev_req_t;

endpackage : clk_host_pkg

// *** core/dev_port.sv ***
// four-phase register access port toward the clock device
`timescale 1ns/1ps
module dev_port (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input clk_host_pkg::dev_req_t cmd_i,
  input wire logic dev_ack_i,
  input wire logic [7:0] dev_rdata_i,
  output logic dev_req_o,
  output clk_host_pkg::dev_req_t dev_cmd_o,
  output logic done_o,
  output logic [7:0] rdata_o
);
  import clk_host_pkg::*;

  logic [1:0] ack_sync_reg;
  logic [7:0] rd_s1_reg;
  logic [7:0] rd_s2_reg;
  logic [1:0] phase_reg;

  // device holds read data before raising ack, so equal sync depth is safe
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_sync_reg <= 2'h0;
      rd_s1_reg <= 8'h00;
      rd_s2_reg <= 8'h00;
    end else begin
      ack_sync_reg <= {ack_sync_reg[0], dev_ack_i};
      rd_s1_reg <= dev_rdata_i;
      rd_s2_reg <= rd_s1_reg;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      phase_reg <= 2'h0;
      dev_req_o <= 1'b0;
      dev_cmd_o <= '0;
      done_o <= 1'b0;
      rdata_o <= 8'h00;
    end else begin
      done_o <= 1'b0;
      unique case (phase_reg)
        2'h0: if (start_i) begin
          dev_req_o <= 1'b1;
          dev_cmd_o <= cmd_i;
          phase_reg <= 2'h1;
        end
        2'h1: if (ack_sync_reg[1]) begin
          dev_req_o <= 1'b0;
          rdata_o <= rd_s2_reg;
          phase_reg <= 2'h2;
        end
        2'h2: if (!ack_sync_reg[1]) begin
          done_o <= 1'b1;
          phase_reg <= 2'h0;
        end
        default: phase_reg <= 2'h0;
      endcase
    end
  end

  req_hold_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    dev_req_o && !ack_sync_reg[1] |=> dev_req_o && $stable(dev_cmd_o))
    else $error("device request dropped before ack");

endmodule : dev_port

// *** core/cpu_clk_host.sv ***
// ahb-lite controlled sequencer that moves the device cpu clock between sources
`timescale 1ns/1ps
module cpu_clk_host (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic dev_req_o,
  output clk_host_pkg::dev_req_t dev_cmd_o,
  input wire logic dev_ack_i,
  input wire logic [7:0] dev_rdata_i
);
  import clk_host_pkg::*;

  // ****************************************
  // declarations
  // ****************************************
  logic addr_ok;
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;
  logic [31:0] rd_mux;
  clk_cmd_t cmd_reg;
  logic [15:0] stab_wait_reg;
  logic [7:0] stab_mask_reg;
  logic done_reg;
  logic err_reg;
  logic go;
  logic refuse;
  seq_state_t state_reg;
  seq_state_t first_state;
  seq_state_t stab_next;
  logic issued_reg;
  logic [15:0] wait_cnt_reg;
  logic [7:0] settle_cnt_reg;
  logic stab_ok_reg;
  clk_src_t cur_src_reg;
  clk_src_t target_src;
  logic [7:0] pin_reg;
  logic [7:0] moc_reg;
  logic [7:0] mcm_reg;
  logic [7:0] pcc_reg;
  logic [7:0] rcm_reg;
  logic highspeed_src_sel_used_reg;
  logic main_cmd;
  logic sub_cmd;
  logic ext_cmd;
  logic acc_state;
  logic acc_start;
  logic acc_done;
  logic [7:0] acc_rdata;
  logic stab_seen;
  dev_req_t acc_req;

  // ****************************************
  // ahb-lite slave, zero wait states
  // ****************************************
  assign addr_ok = hsel_i && htrans_i[1] && hready_i;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      hrdata_o <= 32'h0000_0000;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end else begin
      wr_pend_reg <= addr_ok && hwrite_i;
      if (addr_ok) begin
        wr_addr_reg <= haddr_i[7:0];
      end
      if (addr_ok && !hwrite_i) begin
        hrdata_o <= rd_mux;
      end
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (haddr_i[7:0])
      AREG_CMD: rd_mux[2:0] = cmd_reg;
      AREG_STATUS: begin
        rd_mux[STAT_BUSY_BIT] = (state_reg != ST_IDLE);
        rd_mux[STAT_DONE_BIT] = done_reg;
        rd_mux[STAT_HIGHSPEED_SRC_SEL_BIT] = highspeed_src_sel_used_reg;
        rd_mux[STAT_ERR_BIT] = err_reg;
        rd_mux[STAT_SRC_LSB +: 2] = cur_src_reg;
      end
      AREG_STAB_WAIT: rd_mux[15:0] = stab_wait_reg;
      AREG_STAB_MASK: rd_mux[7:0] = stab_mask_reg;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // a go while busy is ignored; busy shows in status
  assign go = wr_pend_reg && (wr_addr_reg == AREG_CMD) && hwdata_i[CMD_GO_BIT]
    && (state_reg == ST_IDLE);

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cmd_reg <= CMD_TO_X1;
      stab_wait_reg <= STAB_WAIT_RST;
      stab_mask_reg <= STAB_MASK_RST;
    end else if (wr_pend_reg) begin
      if (go) begin
        cmd_reg <= clk_cmd_t'(hwdata_i[2:0]);
      end
      if (wr_addr_reg == AREG_STAB_WAIT) begin
        stab_wait_reg <= hwdata_i[15:0];
      end
      if (wr_addr_reg == AREG_STAB_MASK) begin
        stab_mask_reg <= hwdata_i[7:0];
      end
    end
  end

  // done: write one to clear, a finishing sequence wins over the clear
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      done_reg <= 1'b0;
    end else if (state_reg == ST_DONE) begin
      done_reg <= 1'b1;
    end else if (wr_pend_reg && wr_addr_reg == AREG_STATUS && hwdata_i[STAT_DONE_BIT]) begin
      done_reg <= 1'b0;
    end
  end

  // ****************************************
  // command decode
  // ****************************************
  assign main_cmd = (cmd_reg == CMD_TO_X1) || (cmd_reg == CMD_TO_EXT_MAIN);
  assign sub_cmd = (cmd_reg == CMD_TO_XT1) || (cmd_reg == CMD_TO_EXT_SUB);
  assign ext_cmd = (cmd_reg == CMD_TO_EXT_MAIN) || (cmd_reg == CMD_TO_EXT_SUB);
  assign target_src = main_cmd ? SRC_MAIN : (sub_cmd ? SRC_SUB : SRC_HSOSC);

  always_comb begin
    clk_cmd_t c;
    c = clk_cmd_t'(hwdata_i[2:0]);
    refuse = 1'b0;
    first_state = ST_PIN;
    unique case (c)
      CMD_TO_X1, CMD_TO_EXT_MAIN: begin
        refuse = (cur_src_reg == SRC_SUB) || (highspeed_src_sel_used_reg && !mcm_reg[MCM_HS_SRC_BIT]);
        first_state = (refuse || cur_src_reg == SRC_MAIN) ? ST_DONE : ST_PIN;
      end
      CMD_TO_XT1, CMD_TO_EXT_SUB: begin
        first_state = (cur_src_reg == SRC_SUB) ? ST_DONE : ST_PIN;
      end
      CMD_TO_HSOSC: first_state = (cur_src_reg == SRC_HSOSC) ? ST_DONE : ST_OSC;
      default: begin
        refuse = 1'b1;
        first_state = ST_DONE;
      end
    endcase
  end

  // ****************************************
  // device access request per step
  // ****************************************
  always_comb begin
    acc_req = '0;
    unique case (state_reg)
      ST_PIN: begin
        acc_req.we = 1'b1;
        acc_req.addr = DREG_PIN_MODE;
        acc_req.wdata = pin_reg;
        if (main_cmd) begin
          acc_req.wdata[PIN_EXT_MAIN_BIT] = ext_cmd;
          acc_req.wdata[PIN_X1_MODE_BIT] = 1'b1;
        end else begin
          acc_req.wdata[PIN_EXT_SUB_BIT] = ext_cmd;
          acc_req.wdata[PIN_XT1_MODE_BIT] = 1'b1;
        end
      end
      ST_OSC: begin
        acc_req.we = 1'b1;
        if (main_cmd) begin
          acc_req.addr = DREG_MAIN_OSC;
          acc_req.wdata = moc_reg;
          acc_req.wdata[MOC_STOP_BIT] = 1'b0;
        end else if (sub_cmd) begin
          // start bit cleared, pin mode already set in ST_PIN
          acc_req.addr = DREG_CPU_CLK;
          acc_req.wdata = pcc_reg;
          acc_req.wdata[PCC_XT1_START_BIT] = 1'b0;
        end else begin
          acc_req.addr = DREG_INT_OSC;
          acc_req.wdata = rcm_reg;
          acc_req.wdata[RCM_STOP_BIT] = 1'b0;
        end
      end
      ST_STAB: begin
        acc_req.addr = (cmd_reg == CMD_TO_X1) ? DREG_OSC_STAB : DREG_INT_OSC;
      end
      ST_SEL1: begin
        acc_req.we = 1'b1;
        if (main_cmd) begin
          // source bit kept when already one
          acc_req.addr = DREG_MAIN_CLK;
          acc_req.wdata = mcm_reg;
          acc_req.wdata[MCM_HS_SRC_BIT] = 1'b1;
          acc_req.wdata[MCM_MAIN_SRC_BIT] = 1'b1;
        end else if (sub_cmd) begin
          acc_req.addr = DREG_CPU_CLK;
          acc_req.wdata = pcc_reg;
          acc_req.wdata[PCC_SUB_SEL_BIT] = 1'b1;
        end else begin
          acc_req.addr = DREG_MAIN_CLK;
          acc_req.wdata = mcm_reg;
          acc_req.wdata[MCM_MAIN_SRC_BIT] = 1'b0;
        end
      end
      ST_SEL2: begin
        acc_req.we = 1'b1;
        acc_req.addr = DREG_CPU_CLK;
        acc_req.wdata = pcc_reg;
        acc_req.wdata[PCC_SUB_SEL_BIT] = 1'b0;
      end
      default: acc_req = '0;
    endcase
  end

  assign acc_state = (state_reg == ST_PIN) || (state_reg == ST_OSC) || (state_reg == ST_SEL1)
    || (state_reg == ST_SEL2) || (state_reg == ST_STAB && cmd_reg != CMD_TO_XT1);
  assign acc_start = acc_state && !issued_reg;

  dev_port u_dev_port (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .start_i(acc_start),
    .cmd_i(acc_req),
    .dev_ack_i(dev_ack_i),
    .dev_rdata_i(dev_rdata_i),
    .dev_req_o(dev_req_o),
    .dev_cmd_o(dev_cmd_o),
    .done_o(acc_done),
    .rdata_o(acc_rdata)
  );

  // stable flag read-only at bit 7
  assign stab_seen = (cmd_reg == CMD_TO_X1) ? ((acc_rdata & stab_mask_reg) == stab_mask_reg)
    : acc_rdata[RCM_STABLE_BIT];
  // main source clear skipped with source bit zero
  assign stab_next = (cmd_reg == CMD_TO_HSOSC && cur_src_reg == SRC_SUB
    && !mcm_reg[MCM_HS_SRC_BIT]) ? ST_SEL2 : ST_SEL1;

  // ****************************************
  // sequencer
  // ****************************************
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= ST_IDLE;
      issued_reg <= 1'b0;
      wait_cnt_reg <= 16'h0000;
      settle_cnt_reg <= 8'h00;
      stab_ok_reg <= 1'b0;
      err_reg <= 1'b0;
      cur_src_reg <= SRC_HSOSC;
    end else begin
      if (acc_start) begin
        issued_reg <= 1'b1;
      end
      if (acc_done) begin
        issued_reg <= 1'b0;
      end
      unique case (state_reg)
        ST_IDLE: if (go) begin
          stab_ok_reg <= 1'b0;
          err_reg <= refuse;
          wait_cnt_reg <= stab_wait_reg;
          state_reg <= first_state;
        end
        ST_PIN: if (acc_done) begin
          state_reg <= ST_OSC;
        end
        // external clocks skip the stabilization step
        ST_OSC: if (acc_done) begin
          state_reg <= ext_cmd ? ST_SEL1 : ST_STAB;
        end
        ST_STAB: begin
          if (cmd_reg == CMD_TO_XT1) begin
            if (wait_cnt_reg == 16'h0000) begin
              stab_ok_reg <= 1'b1;
              state_reg <= ST_SEL1;
            end else begin
              wait_cnt_reg <= wait_cnt_reg - 16'h0001;
            end
          end else if (acc_done && stab_seen) begin
            stab_ok_reg <= 1'b1;
            state_reg <= stab_next;
          end
        end
        ST_SEL1: if (acc_done) begin
          settle_cnt_reg <= SETTLE_LAST;
          state_reg <= (cmd_reg == CMD_TO_HSOSC && cur_src_reg == SRC_SUB) ? ST_SEL2 : ST_SETTLE;
        end
        ST_SEL2: if (acc_done) begin
          settle_cnt_reg <= SETTLE_LAST;
          state_reg <= ST_SETTLE;
        end
        ST_SETTLE: begin
          // old source runs on for a while
          if (settle_cnt_reg == 8'h00) begin
            cur_src_reg <= target_src;
            state_reg <= ST_DONE;
          end else begin
            settle_cnt_reg <= settle_cnt_reg - 8'h01;
          end
        end
        ST_DONE: state_reg <= ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // device register shadows
  // ****************************************
  // pin mode image starts at zero
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_reg <= PIN_MODE_RST;
      moc_reg <= MAIN_OSC_RST;
      mcm_reg <= MAIN_CLK_RST;
      pcc_reg <= CPU_CLK_RST;
      rcm_reg <= INT_OSC_RST;
      highspeed_src_sel_used_reg <= 1'b0;
    end else if (acc_done && acc_req.we) begin
      unique case (acc_req.addr)
        DREG_PIN_MODE: pin_reg <= acc_req.wdata;
        DREG_MAIN_OSC: moc_reg <= acc_req.wdata;
        DREG_MAIN_CLK: begin
          mcm_reg <= acc_req.wdata;
          // device takes the source bit once
          if (acc_req.wdata[MCM_HS_SRC_BIT] != mcm_reg[MCM_HS_SRC_BIT]) begin
            highspeed_src_sel_used_reg <= 1'b1;
          end
        end
        DREG_CPU_CLK: pcc_reg <= acc_req.wdata;
        DREG_INT_OSC: rcm_reg <= acc_req.wdata;
        default: pin_reg <= pin_reg;
      endcase
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);

  sequence settle_start_s;
    $rose(state_reg == ST_SETTLE);
  endsequence
  sequence settle_run_s;
    ##15 (state_reg == ST_SETTLE) ##1 (state_reg == ST_DONE);
  endsequence

  highspeed_src_sel_locked_a: assert property (highspeed_src_sel_used_reg |=> $stable(mcm_reg[MCM_HS_SRC_BIT]))
    else $error("source bit changed twice");
  x1_stab_first_a: assert property (
    (state_reg == ST_SEL1 && cmd_reg == CMD_TO_X1) |-> stab_ok_reg && !moc_reg[MOC_STOP_BIT])
    else $error("X1 selected before stabilization");
  ext_main_nopoll_a: assert property (
    (cmd_reg == CMD_TO_EXT_MAIN && $past(state_reg) == ST_OSC && state_reg != ST_OSC)
    |-> state_reg == ST_SEL1)
    else $error("external main clock polled");
  xt1_wait_a: assert property (
    (state_reg == ST_SEL1 && cmd_reg == CMD_TO_XT1) |-> stab_ok_reg && wait_cnt_reg == 16'h0000)
    else $error("XT1 selected before wait");
  ext_sub_nowait_a: assert property (
    (cmd_reg == CMD_TO_EXT_SUB) |-> state_reg != ST_STAB)
    else $error("external sub clock waited");
  hsosc_order_a: assert property (
    (state_reg == ST_SEL1 && cmd_reg == CMD_TO_HSOSC) |-> stab_ok_reg && !rcm_reg[RCM_STOP_BIT])
    else $error("main source cleared before stable");
  sub_clear_last_a: assert property (
    $rose(state_reg == ST_SEL2) |-> stab_ok_reg && (!mcm_reg[MCM_MAIN_SRC_BIT]
    || !mcm_reg[MCM_HS_SRC_BIT]))
    else $error("sub select cleared too early");
  settle_len_a: assert property (settle_start_s |-> settle_run_s)
    else $error("settle period length wrong");
  pin_written_a: assert property (
    (state_reg != ST_PIN) |=> $stable(pin_reg))
    else $error("pin mode changed outside its step");

endmodule : cpu_clk_host

// *** tb/clk_dev_model.sv ***
// behavioural clock device answering the host's four-phase register port
`timescale 1ns/1ps
module clk_dev_model (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic slow_i,
  input wire logic dev_req_i,
  input clk_host_pkg::dev_req_t dev_cmd_i,
  output logic dev_ack_o,
  output logic [7:0] dev_rdata_o
);
  import clk_host_pkg::*;
  logic [7:0] pin_reg, moc_reg, mcm_reg, pcc_reg, rcm_reg, stab_cnt, xt1_cnt, rd, w;
  logic [2:0] hs_cnt;
  logic highspeed_src_sel_used;
  int bad_cnt;
  assign w = dev_cmd_i.wdata;
  // main and internal oscillators run while stop bits clear, XT1 while pin mode selects the crystal
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      stab_cnt <= 8'h00;
      xt1_cnt <= 8'h00;
      hs_cnt <= 3'h0;
    end else begin
      stab_cnt <= moc_reg[7] ? 8'h00 : stab_cnt + {7'h0, stab_cnt != 8'hFF};
      xt1_cnt <= (pin_reg[5:4] == 2'b01) ? xt1_cnt + {7'h0, xt1_cnt != 8'hFF} : 8'h00;
      hs_cnt <= rcm_reg[0] ? 3'h0 : hs_cnt + {2'h0, hs_cnt != 3'h7};
    end
  end
  always_comb begin
    case (dev_cmd_i.addr)
      DREG_PIN_MODE: rd = pin_reg;
      DREG_MAIN_OSC: rd = moc_reg;
      DREG_MAIN_CLK: rd = mcm_reg;
      DREG_CPU_CLK: rd = pcc_reg;
      DREG_INT_OSC: rd = {hs_cnt == 3'h7, rcm_reg[6:0]};
      DREG_OSC_STAB: rd = stab_cnt;
      default: rd = 8'h00;
    endcase
  end
  initial begin
    dev_ack_o = 1'b0;
    dev_rdata_o = 8'h5A;
    bad_cnt = 0;
    forever begin
      @(posedge sys_clk_i);
      if (rst_i) begin
        pin_reg <= 8'h00;
        moc_reg <= 8'h80;
        mcm_reg <= 8'h00;
        pcc_reg <= 8'h00;
        rcm_reg <= 8'h00;
        highspeed_src_sel_used <= 1'b0;
      end else if (dev_req_i) begin
        repeat (slow_i ? 6 : 1) @(posedge sys_clk_i);
        if (dev_cmd_i.we) begin
          case (dev_cmd_i.addr)
            DREG_PIN_MODE: pin_reg <= w;
            DREG_MAIN_OSC: moc_reg <= w;
            DREG_MAIN_CLK: begin
              if (w[0] && !mcm_reg[0] && pin_reg[7:6] == 2'b01 && stab_cnt != 8'hFF) bad_cnt++;
              if (!w[0] && mcm_reg[0] && hs_cnt != 3'h7) bad_cnt++;
              if (w[2] != mcm_reg[2] && highspeed_src_sel_used) bad_cnt++;
              highspeed_src_sel_used <= highspeed_src_sel_used | (w[2] != mcm_reg[2]);
              mcm_reg <= {w[7:3], highspeed_src_sel_used ? mcm_reg[2] : w[2], w[1:0]};
            end
            DREG_CPU_CLK: begin
              if (w[4] && !pcc_reg[4] && pin_reg[5:4] == 2'b01 && xt1_cnt < 8'h04) bad_cnt++;
              if (!w[4] && pcc_reg[4] && mcm_reg[0]) bad_cnt++;
              pcc_reg <= w;
            end
            DREG_INT_OSC: rcm_reg <= w;
            default: ;
          endcase
        end
        dev_rdata_o <= rd;
        @(posedge sys_clk_i);
        dev_ack_o <= 1'b1;
        while (dev_req_i) @(posedge sys_clk_i);
        dev_ack_o <= 1'b0;
        // released data lines flip, so stale bytes are never mistaken
        dev_rdata_o <= ~dev_rdata_o;
      end
    end
  end
endmodule : clk_dev_model

// *** tb/cpu_clk_host_tb.sv ***
// self-checking bench for the cpu clock source switch host
`timescale 1ns/1ps
module cpu_clk_host_tb;
  import clk_host_pkg::*;
  logic clk, rst, sel, wr, ready, req, ack, slow, resp;
  logic [1:0] trans;
  logic [31:0] addr, wdata, rdata, rd;
  logic [7:0] drd;
  dev_req_t cmd;
  int n_errors, compares, cycles;
  cpu_clk_host uut (.sys_clk_i(clk), .rst_i(rst), .hsel_i(sel), .haddr_i(addr),
    .htrans_i(trans), .hwrite_i(wr), .hsize_i(3'h2), .hwdata_i(wdata), .hready_i(ready),
    .hrdata_o(rdata), .hreadyout_o(ready), .hresp_o(resp), .dev_req_o(req), .dev_cmd_o(cmd),
    .dev_ack_i(ack), .dev_rdata_i(drd));
  clk_dev_model dev (.sys_clk_i(clk), .rst_i(rst), .slow_i(slow), .dev_req_i(req),
    .dev_cmd_i(cmd), .dev_ack_o(ack), .dev_rdata_o(drd));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // ****************************************
  // bus access and checking
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // entered right after a rising edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    sel <= 1'b1;
    trans <= 2'h2;
    addr <= {24'h0, a};
    wr <= w;
    @(posedge clk);
    while (ready !== 1'b1) @(posedge clk);
    trans <= 2'h0;
    wdata <= d;
    @(posedge clk);
    while (ready !== 1'b1) @(posedge clk);
    rd = rdata;
  endtask : xfer
  // regs: expected pin mode, main clock mode and cpu clock images
  task automatic run(input logic [2:0] c, input logic [1:0] src, input logic e,
                     input logic [23:0] regs);
    xfer(1'b1, AREG_STATUS, 32'h2);
    xfer(1'b1, AREG_CMD, {23'h0, 1'b1, 5'h0, c});
    xfer(1'b0, AREG_STATUS, 32'h0);
    for (int i = 0; i < 3000 && rd[0] === 1'b1; i++) xfer(1'b0, AREG_STATUS, 32'h0);
    // a poll limit that runs out leaves busy set and counts as a mismatch
    check({31'h0, rd[0]}, 32'h0);
    check({29'h0, rd[5:3]}, {29'h0, src, e});
    if (!e) check({31'h0, rd[1]}, 32'h1);
    check({8'h0, dev.pin_reg, dev.mcm_reg, dev.pcc_reg}, {8'h0, regs});
  endtask : run
  task automatic tally_and_finish;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish
  // ****************************************
  // hang guard and main sequence
  // ****************************************
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  initial begin
    rst = 1'b1;
    sel = 1'b0;
    addr = 32'h0;
    trans = 2'h0;
    wr = 1'b0;
    wdata = 32'h0;
    slow = 1'b0;
    n_errors = 0;
    compares = 0;
    cycles = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    xfer(1'b0, AREG_STATUS, 32'h0);
    check(rd, 32'h0);
    check({31'h0, resp}, 32'h0);
    xfer(1'b0, AREG_STAB_WAIT, 32'h0);
    check(rd, {16'h0, STAB_WAIT_RST});
    xfer(1'b0, AREG_STAB_MASK, 32'h0);
    check(rd, 32'hFF);
    xfer(1'b1, 8'h40, 32'hFFFF_FFFF);
    xfer(1'b0, 8'h40, 32'h0);
    check(rd, 32'h0);
    xfer(1'b1, AREG_STAB_WAIT, 32'h4);
    xfer(1'b0, AREG_STAB_WAIT, 32'h0);
    check(rd, 32'h4);
    check({24'h0, dev.pin_reg}, 32'h0);
    run(3'h0, 2'h1, 1'b0, 24'h40_05_00);
    run(3'h4, 2'h0, 1'b0, 24'h40_04_00);
    run(3'h1, 2'h1, 1'b0, 24'hC0_05_00);
    run(3'h2, 2'h2, 1'b0, 24'hD0_05_10);
    run(3'h4, 2'h0, 1'b0, 24'hD0_04_00);
    slow <= 1'b1;
    run(3'h3, 2'h2, 1'b0, 24'hF0_04_10);
    run(3'h2, 2'h2, 1'b0, 24'hF0_04_10);
    run(3'h0, 2'h2, 1'b1, 24'hF0_04_10);
    run(3'h5, 2'h2, 1'b1, 24'hF0_04_10);
    // ****************************************
    // second reset: source bit free again
    // ****************************************
    rst <= 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    xfer(1'b0, AREG_STATUS, 32'h0);
    check(rd, 32'h0);
    check({24'h0, dev.pin_reg}, 32'h0);
    run(3'h2, 2'h2, 1'b0, 24'h10_00_10);
    run(3'h4, 2'h0, 1'b0, 24'h10_00_00);
    check(dev.bad_cnt, 32'h0);
    tally_and_finish();
  end
endmodule : cpu_clk_host_tb
